// ===== pps_defines.svh
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define PPS_CLK_PERIOD_NS 25
`define PPS_DEAD_TIME_NS 100
`define PPS_DEAD_CYCLES ((`PPS_DEAD_TIME_NS + `PPS_CLK_PERIOD_NS - 1) / `PPS_CLK_PERIOD_NS)
// Reference oscillator at 250 kHz: 160 cycles per period, 80 per phase slot.
`define PPS_OSC_REF_KHZ 250
`define PPS_OSC_DIV (40000 / `PPS_OSC_REF_KHZ)
`define PPS_HALF_PERIOD (`PPS_OSC_DIV / 2)
`define PPS_ON_CYCLES (`PPS_HALF_PERIOD - `PPS_DEAD_CYCLES)
`define PPS_SHORT_DELAY_MS 100
`define PPS_SLEEP_MS 800
`define PPS_SHORT_TICKS (`PPS_SHORT_DELAY_MS * `PPS_OSC_REF_KHZ)
`define PPS_SLEEP_TICKS (`PPS_SLEEP_MS * `PPS_OSC_REF_KHZ)
`define PPS_CNT_W 20
`define PPS_DIV_W 8

`endif

// ===== pps_pkg.sv
package pps_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PPS_SOFT_START,
    PPS_NORMAL,
    PPS_SHORT
  } pps_mode_t;

  typedef struct packed {
    logic phase_a_on;
    logic phase_b_on;
    logic current_limit;
  } pps_drive_t;

  typedef struct packed {
    pps_mode_t mode;
    logic [7:0] div;
    logic phase_b;
    logic [19:0] ov_time;
    logic [19:0] sleep_time;
    pps_drive_t drive;
  } pps_state_t;

endpackage : pps_pkg

// ===== pps_mode_sequencer.sv
`timescale 1ns/1ps
`include "pps_defines.svh"

// Behaviour
// - Exactly three modes: soft start, normal drive, short hiccup; moves follow drain checks, except the timed exit from short.
// - After reset the sequencer always starts in soft start.
// - Soft start selects current-limited drive of the switches.
// - Soft start moves to normal when drains are at or below threshold.
// - Soft start accumulates over-voltage time; past the short delay it enters short mode.
// - Normal mode drives fully, alternating equal on-times, checking drains each pass.
// - Over-voltage in normal returns to the soft-start time-counting loop.
// - Short mode stops driving, counts sleep time, then re-enters soft start.
// - Phases alternate with equal on-times and a dead time of about 100 ns.
module pps_mode_sequencer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic drain_phase_a,
  input wire logic drain_phase_b,
  output pps_pkg::pps_drive_t drive,
  output pps_pkg::pps_mode_t mode
);

  localparam logic [7:0] DIV_LAST = 8'(`PPS_OSC_DIV - 1);
  localparam logic [7:0] ON_LAST = 8'(`PPS_ON_CYCLES);
  localparam logic [7:0] HALF = 8'(`PPS_HALF_PERIOD);
  localparam logic [19:0] SHORT_TICKS = 20'(`PPS_SHORT_TICKS);
  localparam logic [19:0] SLEEP_TICKS = 20'(`PPS_SLEEP_TICKS);

  pps_pkg::pps_state_t st;
  pps_pkg::pps_state_t next_st;
  logic slot_end;
  logic period_tick;
  logic over_v;
  logic [7:0] slot_pos;
  logic on_window;

  // ----------------------------------------
  // Oscillator and phase timing
  // ----------------------------------------
  // The drain level is only meaningful while a switch conducts, so it is judged
  // at the end of each phase slot, from the drain of the phase that was on.
  assign period_tick = (st.div == DIV_LAST);
  assign slot_end = (st.div == HALF - 8'h01) || period_tick;
  assign slot_pos = st.phase_b ? st.div - HALF : st.div;
  assign over_v = st.phase_b ? drain_phase_b : drain_phase_a;
  assign on_window = (st.mode != pps_pkg::PPS_SHORT) && (slot_pos < ON_LAST);

  always_comb begin
    next_st = st;
    next_st.div = period_tick ? 8'h00 : st.div + 8'h01;
    if (slot_end) begin
      next_st.phase_b = ~st.phase_b;
    end
    unique case (st.mode)
      pps_pkg::PPS_SOFT_START: begin
        if (slot_end) begin
          if (!over_v) begin
            next_st.mode = pps_pkg::PPS_NORMAL;
            next_st.ov_time = '0;
          end else if (period_tick) begin
            if (st.ov_time >= SHORT_TICKS) begin
              next_st.mode = pps_pkg::PPS_SHORT;
              next_st.sleep_time = '0;
            end else begin
              next_st.ov_time = st.ov_time + 20'h00001;
            end
          end
        end
      end
      pps_pkg::PPS_NORMAL: begin
        if (slot_end && over_v) begin
          next_st.mode = pps_pkg::PPS_SOFT_START;
          next_st.ov_time = '0;
        end
      end
      pps_pkg::PPS_SHORT: begin
        if (period_tick) begin
          if (st.sleep_time >= SLEEP_TICKS - 20'h00001) begin
            next_st.mode = pps_pkg::PPS_SOFT_START;
            next_st.ov_time = '0;
          end else begin
            next_st.sleep_time = st.sleep_time + 20'h00001;
          end
        end
      end
      default: begin
        next_st.mode = pps_pkg::PPS_SOFT_START;
      end
    endcase
    // Drive is registered for the coming cycle; the last slot cycles stay off.
    next_st.drive = '0;
    if (next_st.mode != pps_pkg::PPS_SHORT) begin
      if ((next_st.div < HALF ? next_st.div : next_st.div - HALF) < ON_LAST) begin
        next_st.drive.phase_a_on = ~next_st.phase_b;
        next_st.drive.phase_b_on = next_st.phase_b;
      end
      next_st.drive.current_limit = (next_st.mode == pps_pkg::PPS_SOFT_START);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{mode: pps_pkg::PPS_SOFT_START, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign drive = st.drive;
  assign mode = st.mode;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_short_entered;
    st.mode == pps_pkg::PPS_SHORT && $past(st.mode) == pps_pkg::PPS_SOFT_START;
  endsequence

  property p_three_modes;
    @(posedge clk) disable iff (sys_rst) st.mode != 2'h3;
  endproperty
  a_three_modes: assert property (p_three_modes) else $error("illegal mode");

  property p_reset_soft;
    @(posedge clk) $fell(sys_rst) |-> st.mode == pps_pkg::PPS_SOFT_START;
  endproperty
  a_reset_soft: assert property (p_reset_soft) else $error("mode after reset");

  property p_limit_soft;
    @(posedge clk) disable iff (sys_rst)
      (drive.phase_a_on || drive.phase_b_on)
      |-> drive.current_limit == (mode == pps_pkg::PPS_SOFT_START);
  endproperty
  a_limit_soft: assert property (p_limit_soft) else $error("drive strength wrong");

  property p_to_normal;
    @(posedge clk) disable iff (sys_rst)
      (st.mode == pps_pkg::PPS_SOFT_START && slot_end && !over_v)
      |=> st.mode == pps_pkg::PPS_NORMAL;
  endproperty
  a_to_normal: assert property (p_to_normal) else $error("soft start missed normal");

  property p_short_delay;
    @(posedge clk) disable iff (sys_rst) s_short_entered |-> $past(st.ov_time) >= SHORT_TICKS;
  endproperty
  a_short_delay: assert property (p_short_delay) else $error("short entered early");

  property p_back_soft;
    @(posedge clk) disable iff (sys_rst)
      (st.mode == pps_pkg::PPS_NORMAL && slot_end && over_v)
      |=> st.mode == pps_pkg::PPS_SOFT_START;
  endproperty
  a_back_soft: assert property (p_back_soft) else $error("normal ignored overvoltage");

  property p_sleep_off;
    @(posedge clk) disable iff (sys_rst) s_short_entered |-> (drive == '0) [*8];
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("drive during sleep");

  property p_no_overlap;
    @(posedge clk) disable iff (sys_rst)
      $fell(drive.phase_a_on) |-> (!drive.phase_b_on) [*4];
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("dead time violated");

  property p_equal_on;
    @(posedge clk) disable iff (sys_rst)
      $rose(drive.phase_b_on) |-> $past(drive.phase_a_on, `PPS_DEAD_CYCLES + 1)
        || $past(mode, `PPS_DEAD_CYCLES + 1) == pps_pkg::PPS_SHORT;
  endproperty
  a_equal_on: assert property (p_equal_on) else $error("phase b without a");

  // Entry to and exit from short mode lie millions of cycles apart; the per-period counting
  // steps below guard both counters between those end points.
  sequence s_soft_over_tick;
    st.mode == pps_pkg::PPS_SOFT_START && period_tick && over_v;
  endsequence

  sequence s_sleep_tick;
    st.mode == pps_pkg::PPS_SHORT && period_tick;
  endsequence

  property p_phase_a_slot;
    @(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> drive.phase_a_on == (on_window && !st.phase_b);
  endproperty
  a_phase_a_slot: assert property (p_phase_a_slot) else $error("phase a off its slot");

  property p_phase_b_slot;
    @(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> drive.phase_b_on == (on_window && st.phase_b);
  endproperty
  a_phase_b_slot: assert property (p_phase_b_slot) else $error("phase b off its slot");

  property p_full_drive;
    @(posedge clk) disable iff (sys_rst) mode == pps_pkg::PPS_NORMAL |-> !drive.current_limit;
  endproperty
  a_full_drive: assert property (p_full_drive) else $error("limited drive in normal");

  property p_keep_checking;
    @(posedge clk) disable iff (sys_rst)
      (st.mode == pps_pkg::PPS_SOFT_START && slot_end && over_v && !period_tick)
      |=> st.mode == pps_pkg::PPS_SOFT_START;
  endproperty
  a_keep_checking: assert property (p_keep_checking) else $error("left soft start early");

  property p_ov_count;
    @(posedge clk) disable iff (sys_rst)
      s_soft_over_tick ##0 (st.ov_time < SHORT_TICKS)
      |=> st.ov_time == $past(st.ov_time) + 20'h00001;
  endproperty
  a_ov_count: assert property (p_ov_count) else $error("over-voltage count stalled");

  property p_ov_restart;
    @(posedge clk) disable iff (sys_rst)
      (st.mode == pps_pkg::PPS_NORMAL && slot_end && over_v) |=> st.ov_time == 20'h00000;
  endproperty
  a_ov_restart: assert property (p_ov_restart) else $error("over-voltage time kept");

  property p_sleep_count;
    @(posedge clk) disable iff (sys_rst)
      s_sleep_tick ##0 (st.sleep_time < SLEEP_TICKS - 20'h00001)
      |=> st.sleep_time == $past(st.sleep_time) + 20'h00001;
  endproperty
  a_sleep_count: assert property (p_sleep_count) else $error("sleep count stalled");

  property p_sleep_exit;
    @(posedge clk) disable iff (sys_rst)
      s_sleep_tick ##0 (st.sleep_time >= SLEEP_TICKS - 20'h00001)
      |=> st.mode == pps_pkg::PPS_SOFT_START;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep never ended");

endmodule : pps_mode_sequencer

// ===== pps_stage_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Power stage comparator model
// ----------------------------------------
// A drain shows the load only while its switch conducts; the comparison is held through the
// dead time, when the sequencer samples it.
module pps_stage_model (
  input wire pps_pkg::pps_drive_t drive,
  input wire logic short_out,
  output logic drain_phase_a,
  output logic drain_phase_b
);
  always @* begin
    if (drive.phase_a_on) begin
      drain_phase_a = short_out;
    end
    if (drive.phase_b_on) begin
      drain_phase_b = short_out;
    end
  end
endmodule : pps_stage_model

// ===== pushpull_mode_sequencer_test.sv
`timescale 1ns/1ps
`include "pps_defines.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end

module pushpull_mode_sequencer_test;
  logic clk;
  logic sys_rst;
  logic short_out;
  logic drain_phase_a;
  logic drain_phase_b;
  pps_pkg::pps_drive_t drive;
  pps_pkg::pps_mode_t mode;
  int errors;
  int checks;
  int cycles;

  pps_mode_sequencer pps_mode_sequencer_inst (.clk(clk), .sys_rst(sys_rst),
    .drain_phase_a(drain_phase_a), .drain_phase_b(drain_phase_b), .drive(drive), .mode(mode));
  pps_stage_model pps_stage_model_inst (.drive(drive), .short_out(short_out),
    .drain_phase_a(drain_phase_a), .drain_phase_b(drain_phase_b));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // The whole run needs under 2000 cycles; the ceiling leaves ample room.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      $display("ERROR cycle_limit expected %0d seen %0d", 2000, cycles);
      close_out();
    end
  end

  task automatic wait_mode(input pps_pkg::pps_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_mode

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset(input int len);
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (len) @(negedge clk);
    `CHK("drive_in_reset", 3'h0, drive)
    `CHK("mode_in_reset", pps_pkg::PPS_SOFT_START, mode)
    sys_rst = 1'b0;
    @(negedge clk);
    `CHK("a_on", 1'b1, drive.phase_a_on)
    `CHK("limit", 1'b1, drive.current_limit)
    `CHK("mode_start", pps_pkg::PPS_SOFT_START, mode)
    $display("t_reset done");
  endtask : t_reset

  task automatic t_normal;
    int a_n;
    int b_n;
    int both_n;
    int lim_n;
    a_n = 0;
    b_n = 0;
    both_n = 0;
    lim_n = 0;
    wait_mode(pps_pkg::PPS_NORMAL);
    `CHK("mode_normal", pps_pkg::PPS_NORMAL, mode)
    repeat (`PPS_OSC_DIV) begin
      @(negedge clk);
      a_n += (drive.phase_a_on === 1'b1);
      b_n += (drive.phase_b_on === 1'b1);
      both_n += (drive.phase_a_on !== 1'b0 && drive.phase_b_on !== 1'b0);
      lim_n += (drive.current_limit !== 1'b0);
    end
    `CHK("a_on_cycles", `PPS_ON_CYCLES, a_n)
    `CHK("b_on_cycles", `PPS_ON_CYCLES, b_n)
    `CHK("both_on", 0, both_n)
    `CHK("full_drive", 0, lim_n)
    $display("t_normal done");
  endtask : t_normal

  task automatic t_overvoltage;
    int n;
    n = 0;
    short_out = 1'b1;
    wait_mode(pps_pkg::PPS_SOFT_START);
    `CHK("mode_back", pps_pkg::PPS_SOFT_START, mode)
    while (drive.phase_a_on !== 1'b1 && drive.phase_b_on !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    `CHK("limit_again", 1'b1, drive.current_limit)
    // Over-voltage far below the short delay must keep the sequencer checking in soft start.
    repeat (400) @(negedge clk);
    `CHK("mode_hold", pps_pkg::PPS_SOFT_START, mode)
    short_out = 1'b0;
    wait_mode(pps_pkg::PPS_NORMAL);
    `CHK("mode_recover", pps_pkg::PPS_NORMAL, mode)
    $display("t_overvoltage done");
  endtask : t_overvoltage

  initial begin
    sys_rst = 1'b1;
    short_out = 1'b0;
    t_reset(6);
    t_normal();
    t_overvoltage();
    t_reset(2);
    t_normal();
    close_out();
  end
endmodule : pushpull_mode_sequencer_test
